// ==== rmh_msg_handler.sv ====
// Redundancy status and change message handler with a small register port.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "rmh_params.svh"
module rmh_msg_handler (
	// Clock and reset.
	input  wire logic               clk,
	input  wire logic               srst,
	// Received bytes from the link framer.
	input  wire rmh_pkg::rmh_byte_t rx,
	// Transmitted bytes towards the link framer.
	input  wire logic               tx_ready,
	output var  rmh_pkg::rmh_byte_t tx,
	// Register port.
	input  wire logic [3:0]         bus_addr,
	input  wire logic [31:0]        bus_wdata,
	input  wire logic               bus_wr,
	input  wire logic               bus_rd,
	output var  logic [31:0]        bus_rdata
);
	import rmh_pkg::*;

	// ********************************************************************
	// State
	// ********************************************************************
	rmh_state_t  state_ff, nxt_state;
	rmh_kind_t   kind_ff, nxt_kind;
	logic [3:0]  idx_ff, nxt_idx;
	logic [3:0]  len_ff, nxt_len;
	logic [7:0]  sum_ff, nxt_sum;
	logic [7:0]  frm_ff [0:9];
	logic [7:0]  nxt_frm [0:9];
	rmh_cfg_t    cfg_ff, nxt_cfg;
	rmh_set_t    set_ff, nxt_set;
	logic [7:0]  cnt_ok_ff, nxt_cnt_ok;
	logic [7:0]  cnt_bad_ff, nxt_cnt_bad;
	rmh_byte_t   tx_ff, nxt_tx;
	logic [31:0] rdata_ff, nxt_rdata;

	// ********************************************************************
	// Frame checks on the final byte
	// ********************************************************************
	logic       fin, hdr_ok, stat_ok, chg_ok;
	logic       mode_ok, sys_ok, unit_ok, prio_ok;
	logic       ap_mode, ap_unit, ap_prio, ap_sys;
	logic [7:0] sys_lo, prio_d;
	logic [3:0] sys_val;
	rmh_unit_t  unit_req;
	logic       set_wr;

	assign set_wr = bus_wr && (bus_addr == `RMH_ADDR_SET);

	// The checksum is the byte sum from the start byte through the end byte.
	always_comb begin
		fin = (state_ff == RMH_ST_RX) && rx.valid && (idx_ff > `RMH_POS_INS) && (idx_ff == len_ff - `RMH_IDX_ONE);
		hdr_ok = (frm_ff[`RMH_POS_ADDR] == cfg_ff.addr) // R18
			&& (frm_ff[idx_ff - `RMH_IDX_ONE] == `RMH_ETX)
			&& (rx.data == sum_ff); // R17
		stat_ok = fin && hdr_ok && (frm_ff[`RMH_POS_INS] == `RMH_INS_STAT); // R1
		mode_ok = (frm_ff[`RMH_CHG_MODE] == `RMH_CH_M) || (frm_ff[`RMH_CHG_MODE] == `RMH_CH_A);
		sys_lo = frm_ff[`RMH_CHG_SYSL] - `RMH_CH_0;
		sys_ok = ((frm_ff[`RMH_CHG_SYSH] == `RMH_CH_0) && (sys_lo <= `RMH_DIG_MAX))
			|| ((frm_ff[`RMH_CHG_SYSH] == `RMH_CH_1) && (frm_ff[`RMH_CHG_SYSL] == `RMH_CH_0)); // R9
		sys_val = (frm_ff[`RMH_CHG_SYSH] == `RMH_CH_1) ? `RMH_SYS_MAX : sys_lo[3:0];
		prio_d = frm_ff[`RMH_CHG_PRIO] - `RMH_CH_1;
		unit_req = (frm_ff[`RMH_CHG_UNIT] == `RMH_CH_B) ? RMH_U_B
			: ((frm_ff[`RMH_CHG_UNIT] == `RMH_CH_S) ? RMH_U_S : RMH_U_A);
		unit_ok = 1'b0;
		prio_ok = 1'b0;
		ap_mode = 1'b0;
		ap_unit = 1'b0;
		ap_prio = 1'b0;
		ap_sys = 1'b0;
		// Only the fields that the arrangement lets change are checked for range.
		case (cfg_ff.arr)
			RMH_ARR_1F1: begin
				unit_ok = (frm_ff[`RMH_CHG_UNIT] == `RMH_CH_A) || (frm_ff[`RMH_CHG_UNIT] == `RMH_CH_B); // R11
				prio_ok = mode_ok && sys_ok && unit_ok; // R12
				ap_mode = 1'b1; // R13
				ap_sys = 1'b1;
				ap_unit = !set_ff.auto_mode && !cfg_ff.online; // R14
			end
			RMH_ARR_1F2: begin
				if (cfg_ff.id == RMH_U_S) begin
					unit_ok = (frm_ff[`RMH_CHG_UNIT] == `RMH_CH_A) || (frm_ff[`RMH_CHG_UNIT] == `RMH_CH_B)
						|| (frm_ff[`RMH_CHG_UNIT] == `RMH_CH_S); // R11
					prio_ok = mode_ok && sys_ok && unit_ok;
					ap_mode = 1'b1; // R15
					ap_unit = 1'b1;
					ap_sys = 1'b1;
				end else begin
					prio_ok = prio_d <= `RMH_PRIO_MAX2; // R12
					ap_prio = 1'b1; // R15
				end
			end
			RMH_ARR_1FN: begin
				prio_ok = mode_ok && sys_ok && (prio_d <= `RMH_PRIO_MAXN); // R12
				ap_mode = 1'b1;
				ap_prio = 1'b1;
				ap_sys = 1'b1;
			end
			default: begin
				prio_ok = 1'b0;
			end
		endcase
		chg_ok = fin && hdr_ok && (frm_ff[`RMH_POS_INS] == `RMH_INS_CHG) && prio_ok; // R10
	end

	// ********************************************************************
	// Reply byte selection
	// ********************************************************************
	logic [7:0] rpl;

	// The end byte is placed just before the checksum, so one test serves both reply kinds.
	always_comb begin
		rpl = `RMH_ETX;
		if (idx_ff != len_ff - `RMH_POS_TWO) begin
			case (idx_ff)
				`RMH_POS_ADDR: rpl = cfg_ff.addr;
				`RMH_POS_INS: rpl = frm_ff[`RMH_POS_INS]; // R16
				`RMH_RPL_ARR: rpl = (cfg_ff.arr == RMH_ARR_1F1) ? `RMH_CH_1
					: ((cfg_ff.arr == RMH_ARR_1F2) ? `RMH_CH_2 : `RMH_CH_N); // R3
				`RMH_RPL_MODE: rpl = set_ff.auto_mode ? `RMH_CH_A : `RMH_CH_M; // R4
				`RMH_RPL_ONL: rpl = cfg_ff.online ? `RMH_CH_1 : `RMH_CH_0; // R4
				`RMH_RPL_ID: rpl = (cfg_ff.id == RMH_U_B) ? `RMH_CH_B
					: ((cfg_ff.id == RMH_U_S && cfg_ff.arr == RMH_ARR_1F2) ? `RMH_CH_S : `RMH_CH_A); // R5
				`RMH_RPL_PRIO: rpl = (cfg_ff.arr == RMH_ARR_1F1 || cfg_ff.id == RMH_U_S) ? `RMH_CH_X
					: `RMH_CH_1 + {5'h00, set_ff.prio}; // R6
				`RMH_RPL_OUNIT: begin
					if (!cfg_ff.ctrl) begin
						rpl = `RMH_CH_AT; // R7
					end else if (cfg_ff.arr == RMH_ARR_1F1
						|| (cfg_ff.arr == RMH_ARR_1F2 && cfg_ff.id == RMH_U_S)) begin
						rpl = (set_ff.ounit == RMH_U_B) ? `RMH_CH_B
							: ((set_ff.ounit == RMH_U_S) ? `RMH_CH_S : `RMH_CH_A);
					end else begin
						rpl = `RMH_CH_X;
					end
				end
				`RMH_RPL_COAX: rpl = !cfg_ff.ctrl ? `RMH_CH_0 : (cfg_ff.coax ? `RMH_CH_2 : `RMH_CH_1); // R8
				`RMH_RPL_SYSH: rpl = (set_ff.sys == `RMH_SYS_MAX) ? `RMH_CH_1 : `RMH_CH_0; // R9
				`RMH_RPL_SYSL: rpl = (set_ff.sys == `RMH_SYS_MAX) ? `RMH_CH_0 : `RMH_CH_0 + {4'h0, set_ff.sys};
				default: rpl = `RMH_ETX;
			endcase
		end
	end

	// ********************************************************************
	// Next-state logic: receiver, transmitter and registers
	// ********************************************************************
	// The receiver ignores bytes while a reply is out; the link is half duplex.
	always_comb begin
		nxt_state = state_ff;
		nxt_kind = kind_ff;
		nxt_idx = idx_ff;
		nxt_len = len_ff;
		nxt_sum = sum_ff;
		nxt_frm = frm_ff;
		nxt_cfg = cfg_ff;
		nxt_set = set_ff;
		nxt_cnt_ok = cnt_ok_ff;
		nxt_cnt_bad = cnt_bad_ff;
		nxt_tx = tx_ff;
		nxt_rdata = 32'h0000_0000;
		if (bus_wr && bus_addr == `RMH_ADDR_CFG) begin
			nxt_cfg = rmh_cfg_t'(bus_wdata[$bits(rmh_cfg_t)-1:0]);
		end
		if (set_wr) begin
			nxt_set = rmh_set_t'(bus_wdata[$bits(rmh_set_t)-1:0]);
		end
		if (bus_rd) begin
			case (bus_addr)
				`RMH_ADDR_CFG: nxt_rdata = 32'(cfg_ff);
				`RMH_ADDR_SET: nxt_rdata = 32'(set_ff);
				`RMH_ADDR_STAT: nxt_rdata = 32'({state_ff == RMH_ST_TX, cnt_bad_ff, cnt_ok_ff});
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
		case (state_ff)
			RMH_ST_RX: begin
				if (rx.valid) begin
					nxt_frm[idx_ff] = rx.data;
					nxt_sum = sum_ff + rx.data;
					nxt_idx = idx_ff + `RMH_IDX_ONE;
					if (idx_ff == `RMH_POS_STX) begin
						nxt_sum = rx.data;
						nxt_idx = (rx.data == `RMH_STX) ? `RMH_POS_ONE : `RMH_POS_STX;
					end else if (idx_ff == `RMH_POS_INS) begin
						nxt_len = (rx.data == `RMH_INS_STAT) ? `RMH_LEN_SREQ
							: ((rx.data == `RMH_INS_CHG) ? `RMH_LEN_CREQ : `RMH_LEN_NONE);
						if (nxt_len == `RMH_LEN_NONE) begin
							nxt_idx = `RMH_POS_STX; // R18
							nxt_cnt_bad = cnt_bad_ff + `RMH_CNT_ONE;
						end
					end else if (fin) begin
						nxt_idx = `RMH_POS_STX;
						if (stat_ok || chg_ok) begin
							nxt_state = RMH_ST_TX;
							nxt_kind = stat_ok ? RMH_RK_STAT : RMH_RK_ACK;
							nxt_len = stat_ok ? `RMH_LEN_SRPL : `RMH_LEN_ACK; // R2
							nxt_idx = `RMH_POS_ONE;
							nxt_tx = '{valid: 1'b1, data: `RMH_ACK}; // R16
							nxt_sum = `RMH_ACK;
							nxt_cnt_ok = cnt_ok_ff + `RMH_CNT_ONE;
						end else begin
							nxt_cnt_bad = cnt_bad_ff + `RMH_CNT_ONE; // R18
						end
						if (chg_ok) begin
							nxt_set.auto_mode = ap_mode ? (frm_ff[`RMH_CHG_MODE] == `RMH_CH_A) : nxt_set.auto_mode;
							nxt_set.ounit = ap_unit ? unit_req : nxt_set.ounit; // R14
							nxt_set.prio = ap_prio ? prio_d[2:0] : nxt_set.prio; // R15
							nxt_set.sys = ap_sys ? sys_val : nxt_set.sys;
						end
					end
				end
			end
			RMH_ST_TX: begin
				if (tx_ready) begin
					if (idx_ff == len_ff) begin
						nxt_tx = '{valid: 1'b0, data: `RMH_CNT_RST};
						nxt_state = RMH_ST_RX;
						nxt_idx = `RMH_POS_STX;
					end else begin
						nxt_tx.data = (idx_ff == len_ff - `RMH_IDX_ONE) ? sum_ff : rpl; // R17
						nxt_sum = sum_ff + rpl;
						nxt_idx = idx_ff + `RMH_IDX_ONE;
					end
				end
			end
			default: begin
				nxt_state = RMH_ST_RX;
			end
		endcase
	end

	// Registers only; every value comes from the process above.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_ff <= RMH_ST_RX;
			kind_ff <= RMH_RK_STAT;
			idx_ff <= `RMH_POS_STX;
			len_ff <= `RMH_LEN_NONE;
			sum_ff <= `RMH_CNT_RST;
			frm_ff <= '{default: `RMH_CNT_RST};
			cfg_ff <= rmh_cfg_t'(`RMH_CFG_RST);
			set_ff <= rmh_set_t'(`RMH_SET_RST);
			cnt_ok_ff <= `RMH_CNT_RST;
			cnt_bad_ff <= `RMH_CNT_RST;
			tx_ff <= '{valid: 1'b0, data: `RMH_CNT_RST};
			rdata_ff <= 32'h0000_0000;
		end else begin
			state_ff <= nxt_state;
			kind_ff <= nxt_kind;
			idx_ff <= nxt_idx;
			len_ff <= nxt_len;
			sum_ff <= nxt_sum;
			frm_ff <= nxt_frm;
			cfg_ff <= nxt_cfg;
			set_ff <= nxt_set;
			cnt_ok_ff <= nxt_cnt_ok;
			cnt_bad_ff <= nxt_cnt_bad;
			tx_ff <= nxt_tx;
			rdata_ff <= nxt_rdata;
		end
	end

	assign tx = tx_ff;
	assign bus_rdata = rdata_ff;

	// ********************************************************************
	// Assertions and covers
	// ********************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	logic [3:0] pos;
	logic       sv;
	assign pos = idx_ff - `RMH_IDX_ONE;
	assign sv = tx_ff.valid && (kind_ff == RMH_RK_STAT);

	ack_first_a: assert property ($rose(tx_ff.valid) |-> tx_ff.data == `RMH_ACK) // R16
		else $error("reply does not open with the acknowledge byte");
	stat_etx_a: assert property (sv && pos == `RMH_RPL_ETX |-> tx_ff.data == `RMH_ETX && len_ff == `RMH_LEN_SRPL) // R2
		else $error("status reply end byte misplaced");
	arr_char_a: assert property (sv && pos == `RMH_RPL_ARR && cfg_ff.arr == RMH_ARR_1F2 |-> tx_ff.data == `RMH_CH_2) // R3
		else $error("arrangement character wrong");
	mode_char_a: assert property (sv && pos == `RMH_RPL_MODE // R4
		|-> tx_ff.data == (set_ff.auto_mode ? `RMH_CH_A : `RMH_CH_M))
		else $error("mode character wrong");
	unit_id_a: assert property (sv && pos == `RMH_RPL_ID && cfg_ff.arr == RMH_ARR_1F1 |-> tx_ff.data != `RMH_CH_S) // R5
		else $error("standby identity in one-for-one");
	prio_x_a: assert property (sv && pos == `RMH_RPL_PRIO && cfg_ff.id == RMH_U_S |-> tx_ff.data == `RMH_CH_X) // R6
		else $error("standby priority not X");
	no_ctrl_a: assert property (sv && pos == `RMH_RPL_OUNIT && !cfg_ff.ctrl |-> tx_ff.data == `RMH_CH_AT) // R7
		else $error("online unit not @ without controller");
	coax_unk_a: assert property (sv && pos == `RMH_RPL_COAX && !cfg_ff.ctrl |-> tx_ff.data == `RMH_CH_0) // R8
		else $error("coax position not 0 without controller");
	sys_tens_a: assert property (sv && pos == `RMH_RPL_SYSH |-> tx_ff.data inside {`RMH_CH_0, `RMH_CH_1}) // R9
		else $error("system number tens digit out of range");
	prio_keep_a: assert property (chg_ok && cfg_ff.arr == RMH_ARR_1F1 && !set_wr |=> $stable(set_ff.prio)) // R13
		else $error("priority changed in one-for-one");
	unit_keep_a: assert property (chg_ok && (set_ff.auto_mode || cfg_ff.online) && cfg_ff.arr == RMH_ARR_1F1 // R14
		&& !set_wr |=> $stable(set_ff.ounit))
		else $error("online unit changed outside manual offline case");
	ab_only_a: assert property (chg_ok && cfg_ff.arr == RMH_ARR_1F2 && cfg_ff.id != RMH_U_S && !set_wr // R15
		|=> $stable(set_ff.sys) && $stable(set_ff.ounit) && $stable(set_ff.auto_mode))
		else $error("unit A or B changed more than priority");
	ack_len_a: assert property (chg_ok |=> tx_ff.valid && len_ff == `RMH_LEN_ACK) // R16
		else $error("accepted change not acknowledged");
	bad_sum_a: assert property (fin && rx.data != sum_ff |=> !tx_ff.valid) // R17
		else $error("reply to a frame with bad checksum");
	foreign_a: assert property (fin && frm_ff[`RMH_POS_ADDR] != cfg_ff.addr && !set_wr // R18
		|=> !tx_ff.valid && $stable(set_ff))
		else $error("foreign frame answered or applied");

	stat_c: cover property (stat_ok ##1 tx_ff.valid [*3]);
	chg_c: cover property (chg_ok && ap_unit);
	prio_c: cover property (chg_ok && ap_prio && cfg_ff.arr == RMH_ARR_1F2);
	bad_c: cover property (fin && !hdr_ok);

endmodule
`default_nettype wire

// ==== rmh_params.svh ====
// Constants for the redundancy message handler: codes, frame positions, register map and reset values.
// Summary of operation
// R1 - Host status query: 02, address, 75, 03, checksum.
// R2 - Status reply: fourteen bytes, 06 first, 03 thirteenth.
// R3 - Reply byte 4: arrangement '1', '2' or 'N'.
// R4 - Byte 5 mode 'M'/'A'; byte 6 online '0'/'1'.
// R5 - Byte 7 unit identity A, B or S.
// R6 - Byte 8 priority, 'X' in 1:1 or standby.
// R7 - Byte 9 online unit; '@' without controller.
// R8 - Byte 10 coax position; '0' without controller.
// R9 - System number is two digits '00' to '10'.
// R10 - Host change frame: ten bytes, instruction 47.
// R11 - Online unit byte: A/B, A/B/S, unused in 1:N.
// R12 - Priority ignored 1:1, '1'-'2' 1:2, '1'-'8' 1:N.
// R13 - 1:1 accepts all changes except priority.
// R14 - 1:1 online change needs manual mode, offline unit.
// R15 - 1:2 standby: all but priority; A/B: priority only.
// R16 - Other good frames get five-byte acknowledge.
// R17 - Checksum checked; bad checksum means malformed frame.
// R18 - Malformed or foreign frames: no reply, no change.
`ifndef RMH_PARAMS_SVH
`define RMH_PARAMS_SVH

// ********************************************************************
// Frame codes and characters
// ********************************************************************
`define RMH_STX       8'h02
`define RMH_ETX       8'h03
`define RMH_ACK       8'h06
`define RMH_INS_STAT  8'h75
`define RMH_INS_CHG   8'h47
`define RMH_CH_0      8'h30
`define RMH_CH_1      8'h31
`define RMH_CH_2      8'h32
`define RMH_CH_AT     8'h40
`define RMH_CH_A      8'h41
`define RMH_CH_B      8'h42
`define RMH_CH_M      8'h4D
`define RMH_CH_N      8'h4E
`define RMH_CH_S      8'h53
`define RMH_CH_X      8'h58
`define RMH_DIG_MAX   8'h09
`define RMH_PRIO_MAX2 8'h01
`define RMH_PRIO_MAXN 8'h07
`define RMH_SYS_MAX   4'hA

// ********************************************************************
// Frame lengths and zero-based byte positions
// ********************************************************************
`define RMH_LEN_NONE  4'h0
`define RMH_LEN_SREQ  4'h5
`define RMH_LEN_CREQ  4'hA
`define RMH_LEN_SRPL  4'hE
`define RMH_LEN_ACK   4'h5
`define RMH_POS_STX   4'h0
`define RMH_POS_ADDR  4'h1
`define RMH_POS_INS   4'h2
`define RMH_POS_ONE   4'h1
`define RMH_POS_TWO   4'h2
`define RMH_CHG_MODE  4'h3
`define RMH_CHG_UNIT  4'h4
`define RMH_CHG_PRIO  4'h5
`define RMH_CHG_SYSH  4'h6
`define RMH_CHG_SYSL  4'h7
`define RMH_RPL_ARR   4'h3
`define RMH_RPL_MODE  4'h4
`define RMH_RPL_ONL   4'h5
`define RMH_RPL_ID    4'h6
`define RMH_RPL_PRIO  4'h7
`define RMH_RPL_OUNIT 4'h8
`define RMH_RPL_COAX  4'h9
`define RMH_RPL_SYSH  4'hA
`define RMH_RPL_SYSL  4'hB
`define RMH_RPL_ETX   4'hC

// ********************************************************************
// Register map and reset values
// ********************************************************************
`define RMH_ADDR_CFG  4'h0
`define RMH_ADDR_SET  4'h4
`define RMH_ADDR_STAT 4'h8
`define RMH_CFG_RST   15'h0000
`define RMH_SET_RST   10'h000
`define RMH_CNT_RST   8'h00
`define RMH_CNT_ONE   8'h01
`define RMH_IDX_ONE   4'h1

`endif

// ==== rmh_pkg.sv ====
// Types shared by the redundancy message handler.
`default_nettype none
package rmh_pkg;

	// ********************************************************************
	// Enumerations
	// ********************************************************************
	typedef enum logic [1:0] {RMH_ARR_1F1 = 2'b00, RMH_ARR_1F2 = 2'b01, RMH_ARR_1FN = 2'b10} rmh_arr_t;
	typedef enum logic [1:0] {RMH_U_A = 2'b00, RMH_U_B = 2'b01, RMH_U_S = 2'b10} rmh_unit_t;
	typedef enum logic {RMH_ST_RX = 1'b0, RMH_ST_TX = 1'b1} rmh_state_t;
	typedef enum logic {RMH_RK_STAT = 1'b0, RMH_RK_ACK = 1'b1} rmh_kind_t;

	// ********************************************************************
	// Carriers
	// ********************************************************************
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} rmh_byte_t;

	// Static configuration written by software; address sits in the low byte.
	typedef struct packed {
		logic       coax;
		logic       ctrl;
		logic       online;
		rmh_unit_t  id;
		rmh_arr_t   arr;
		logic [7:0] addr;
	} rmh_cfg_t;

	// Settings that change requests may modify; priority is stored as digit minus one.
	typedef struct packed {
		logic [3:0] sys;
		logic [2:0] prio;
		rmh_unit_t  ounit;
		logic       auto_mode;
	} rmh_set_t;

endpackage
`default_nettype wire

// ==== rmh_host.sv ====
// Remote controller model: sends request frames and collects reply bytes.
`timescale 1ns/100ps
`default_nettype none
module rmh_host (
	// Clock.
	input  wire logic               clk,
	// Bytes towards the handler.
	output var  rmh_pkg::rmh_byte_t rx,
	// Reply bytes from the handler.
	input  wire rmh_pkg::rmh_byte_t tx,
	output var  logic               tx_ready
);
	import rmh_pkg::*;
	// ********************************************************************
	// Host side of the byte link
	// ********************************************************************
	logic [7:0] got [$];
	bit         slow;

	// Idle link at time zero.
	initial begin
		rx = '0;
		tx_ready = 1'b0;
		slow = 1'b0;
	end

	// Takes reply bytes; when slow, stalls the handler at random.
	always @(posedge clk) begin
		if (tx.valid === 1'b1 && tx_ready)
			got.push_back(tx.data);
		tx_ready <= slow ? ($urandom % 3 == 0) : 1'b1;
	end

	// One byte per cycle; afterwards valid drops and the data lines carry the last byte inverted so nothing relies on stale data.
	task automatic send(input logic [7:0] f[$]);
		foreach (f[i]) begin
			@(posedge clk);
			rx <= {1'b1, f[i]};
		end
		@(posedge clk);
		rx <= {1'b0, ~f[f.size() - 1]};
	endtask
endmodule
`default_nettype wire

// ==== rmh_msg_handler_bench.sv ====
// Self-checking bench for the redundancy message handler.
`timescale 1ns/100ps
`default_nettype none
module rmh_msg_handler_bench;
	import rmh_pkg::*;
	// ********************************************************************
	// Signals and model state
	// ********************************************************************
	typedef logic [7:0] rmh_q_t [$];
	logic        clk;
	logic        srst;
	logic        bus_wr;
	logic        bus_rd;
	logic [3:0]  bus_addr;
	logic [31:0] bus_wdata;
	logic [31:0] bus_rdata;
	rmh_byte_t   rx;
	rmh_byte_t   tx;
	logic        tx_ready;
	int          miscompares;
	int          checks_done;
	int          n_ok;
	int          n_bad;
	int          addr, arr, uid, onl, ctrl, coax, md, ou, pr, sy;

	rmh_msg_handler uut (.clk(clk), .srst(srst), .rx(rx), .tx_ready(tx_ready), .tx(tx), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
	rmh_host host (.clk(clk), .rx(rx), .tx(tx), .tx_ready(tx_ready));

	// 40 MHz clock.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Cuts a hang short; the whole run needs well under this.
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		wrap_up();
	end

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Bus cycles; read data stand only in the cycle after the strobe.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1 chk(bus_rdata, e);
		@(posedge clk);
		#1 chk(bus_rdata, 32'h0);
	endtask

	function automatic logic [7:0] sum(input rmh_q_t q);
		logic [7:0] s;
		s = 8'h00;
		foreach (q[i]) s += q[i];
		return s;
	endfunction

	// Expected status reply from the model state.
	function automatic rmh_q_t stat_rpl();
		rmh_q_t q;
		bit     sby;
		sby = arr == 0 || (arr == 1 && uid == 2);
		q = '{8'h06, 8'(addr), 8'h75};
		q.push_back(arr == 0 ? "1" : arr == 1 ? "2" : "N");
		q.push_back(md ? "A" : "M");
		q.push_back(onl ? "1" : "0");
		q.push_back(uid == 2 ? (arr == 1 ? "S" : "A") : 8'("A" + uid));
		q.push_back(arr == 0 || uid == 2 ? "X" : 8'("1" + pr));
		q.push_back(!ctrl ? "@" : !sby ? "X" : ou == 2 ? "S" : 8'("A" + ou));
		q.push_back(!ctrl ? "0" : coax ? "2" : "1");
		q.push_back(8'("0" + sy / 10));
		q.push_back(8'("0" + sy % 10));
		q.push_back(8'h03);
		q.push_back(sum(q));
		return q;
	endfunction

	// Sends a frame with its checksum (plus err) and compares whatever comes back.
	task automatic xfer(input rmh_q_t f, input logic [7:0] err, input rmh_q_t exp);
		int n;
		f.push_back(sum(f) + err);
		host.send(f);
		n = 0;
		while (host.got.size() < exp.size() && n < 400) begin
			@(posedge clk);
			n++;
		end
		repeat (30) @(posedge clk);
		chk(32'(host.got.size()), 32'(exp.size()));
		foreach (exp[i]) if (i < host.got.size()) chk(32'(host.got[i]), 32'(exp[i]));
		host.got.delete();
		if (exp.size() > 0)
			n_ok++;
		else
			n_bad++;
	endtask

	task automatic stat();
		xfer('{8'h02, 8'(addr), 8'h75, 8'h03}, 8'h00, stat_rpl());
	endtask

	task automatic chkset();
		rc(4'h4, 32'({4'(sy), 3'(pr), 2'(ou), 1'(md)}));
	endtask

	task automatic cfg(input int a, r, i, o, c, x);
		logic [31:0] w;
		addr = a;
		arr = r;
		uid = i;
		onl = o;
		ctrl = c;
		coax = x;
		w = 32'({1'(x), 1'(c), 1'(o), 2'(i), 2'(r), 8'(a)});
		wr(4'h0, w);
		rc(4'h0, w);
	endtask

	task automatic setw(input int m, u, p, s);
		md = m;
		ou = u;
		pr = p;
		sy = s;
		wr(4'h4, 32'({4'(s), 3'(p), 2'(u), 1'(m)}));
	endtask

	// Change request with the model deciding acceptance and the new settings.
	task automatic chg(input logic [7:0] m, u, p, sh, sl);
		int     s, ok, uc;
		rmh_q_t e;
		s = (int'(sh) - 48) * 10 + int'(sl) - 48;
		uc = u == "A" ? 0 : u == "B" ? 1 : u == "S" ? 2 : 3;
		ok = (m == "M" || m == "A") && sh inside {["0":"9"]} && sl inside {["0":"9"]} && s <= 10;
		if (arr == 0)
			ok = ok && uc < 2;
		else if (arr == 1 && uid == 2)
			ok = ok && uc < 3;
		else if (arr == 1)
			ok = p inside {"1", "2"};
		else
			ok = ok && p inside {["1":"8"]};
		if (ok) begin
			if (arr == 0 && md == 0 && onl == 0)
				ou = uc;
			if (arr == 1 && uid == 2)
				ou = uc;
			if (arr == 2 || (arr == 1 && uid != 2))
				pr = int'(p) - 49;
			if (arr != 1 || uid == 2) begin
				md = m == "A";
				sy = s;
			end
			e = '{8'h06, 8'(addr), 8'h47, 8'h03};
			e.push_back(sum(e));
		end
		xfer('{8'h02, 8'(addr), 8'h47, m, u, p, sh, sl, 8'h03}, 8'h00, e);
		chkset();
	endtask

	// ********************************************************************
	// Main sequence
	// ********************************************************************
	initial begin
		void'($urandom(9963));
		srst = 1'b1;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = 4'h0;
		bus_wdata = 32'h0;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		// Reset values, then an unmapped address that must stay silent.
		rc(4'h0, 32'h0);
		rc(4'h4, 32'h0);
		rc(4'h8, 32'h0);
		wr(4'hC, 32'hFFFFFFFF);
		rc(4'hC, 32'h0);
		// Status reply over every arrangement, identity and controller state.
		for (int r = 0; r < 3; r++) for (int i = 0; i < 3; i++) for (int c = 0; c < 2; c++) begin
			host.slow = c;
			cfg($urandom % 256, r, i, i % 2, c, $urandom % 2);
			setw($urandom % 2, $urandom % (r == 0 ? 2 : 3), $urandom % (r == 1 ? 2 : 8), $urandom % 11);
			stat();
		end
		// One-for-one: online unit follows only in manual mode on the offline unit.
		cfg(8'h20, 0, 0, 0, 1, 0);
		setw(0, 0, 0, 0);
		chg("M", "B", "5", "1", "0");
		chg("A", "A", "9", "0", "4");
		chg("M", "B", "1", "0", "0");
		cfg(8'h20, 0, 1, 1, 1, 0);
		chg("M", "A", "1", "0", "2");
		chg("M", "S", "1", "0", "2");
		chg("Q", "A", "1", "0", "2");
		stat();
		// One-for-two: standby takes all but priority, A or B only priority.
		cfg(8'h21, 1, 2, 0, 1, 1);
		chg("A", "S", "2", "0", "7");
		chg("M", "A", "1", "1", "0");
		stat();
		cfg(8'h22, 1, 0, 1, 1, 0);
		chg("M", "B", "2", "0", "3");
		chg("M", "B", "3", "0", "0");
		stat();
		// One-for-N: boundaries, then random fields, some out of range.
		cfg(8'h23, 2, 0, 1, 0, 0);
		host.slow = 1'b1;
		chg("A", "X", "8", "1", "0");
		chg("A", "A", "9", "0", "0");
		chg("A", "A", "1", "1", "1");
		repeat (16) chg($urandom % 2 ? "M" : "A", "A", 8'("0" + $urandom % 10), 8'("0" + $urandom % 2),
			8'("0" + $urandom % 10));
		stat();
		// Malformed or foreign frames: no reply and no change.
		xfer('{8'h02, 8'(addr), 8'h75, 8'h03}, 8'h01, '{});
		xfer('{8'h02, 8'(addr ^ 1), 8'h75, 8'h03}, 8'h00, '{});
		xfer('{8'h02, 8'(addr), 8'h75, 8'h04}, 8'h00, '{});
		xfer('{8'h02, 8'(addr), 8'h47, "A", "A", "2", "0", "9", 8'h03}, 8'h05, '{});
		chkset();
		stat();
		rc(4'h8, 32'({15'h0, 1'b0, 8'(n_bad), 8'(n_ok)}));
		wrap_up();
	end
endmodule
`default_nettype wire
